/* dv/mbs_master_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ***
// query master on the character link
// ***
module mbs_master_model
  import mbs_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic bit_tick,
  input wire mbs_tx_t tx_out,
  output mbs_rx_t rx_in,
  output logic tx_ready
);
  logic [7:0] send_q[$]; // query bytes still to go
  logic [7:0] reply_q[$]; // reply bytes taken
  int err_at = -1; // character sent with a fault
  int n_sent = 0;
  int ticks = 0;
  logic [3:0] pace = 4'h0; // stall pattern, prompt and slow
  initial rx_in = '0;
  initial tx_ready = 1'b0;
  // one character every ten bit times, in queue order
  always @(posedge ref_clk) begin
    rx_in.valid <= 1'b0;
    rx_in.error <= 1'b0;
    rx_in.data <= ~rx_in.data; // no stale byte between characters
    pace <= pace + 4'h1;
    tx_ready <= pace[1] | pace[3];
    if (tx_out.valid && tx_ready) begin
      reply_q.push_back(tx_out.data);
    end
    if (!rst && bit_tick && send_q.size() > 0) begin
      ticks = ticks + 1;
      if (ticks == 10) begin
        ticks = 0;
        rx_in.valid <= 1'b1;
        rx_in.error <= (n_sent == err_at);
        rx_in.data <= send_q.pop_front();
        n_sent = n_sent + 1;
      end
    end
  end
endmodule // mbs_master_model
`default_nettype wire

/* dv/modbus_rtu_parameter_slave_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module modbus_rtu_parameter_slave_tb
  import mbs_pkg::*;
;
  // ***
  // bench state
  // ***
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] station_addr = 8'h11;
  logic [3:0] baud_sel = 4'h9; // fastest rate keeps the run short
  logic [1:0] parity_sel = 2'h0;
  mbs_rx_t rx_in;
  mbs_tx_t tx_out;
  logic tx_ready;
  logic bit_tick;
  logic [1:0] parity_mode;
  logic [13:0][15:0] param_out;
  logic [13:0][15:0] exp_reg; // predicted register image
  logic [31:0] seed = 32'h1EEDD5CC;
  logic [31:0] v;
  logic [7:0] me; // address byte put in queries
  logic [7:0] f[$]; // query
  logic [7:0] e[$]; // expected reply
  logic [7:0] fc [4] = '{8'h01, 8'h04, 8'h05, 8'h2B};
  logic [7:0] ba [4] = '{8'h0E, 8'h4F, 8'h80, 8'h83};
  logic [7:0] ri [5] = '{8'h07, 8'h08, 8'h0B, 8'h0C, 8'h0D};
  logic [15:0] lim [5] = '{16'h03E8, 16'h003C, 16'h03E8, 16'h0E10, 16'h00FF};
  int n_mismatch = 0;
  int n_compared = 0;
  localparam int SIM_HZ = 384_000; // slow clock figure keeps bit times short
  always #4 ref_clk = ~ref_clk;
  mbs_slave #(.CLK_HZ(SIM_HZ)) u_dut(.ref_clk, .rst, .rx_in, .tx_ready, .tx_out,
    .station_addr, .baud_sel, .parity_sel, .bit_tick, .parity_mode, .param_out);
  mbs_master_model u_mst(.ref_clk, .rst, .bit_tick, .tx_out, .rx_in, .tx_ready);
  // ***
  // helpers
  // ***
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [15:0] crc(input logic [7:0] b[$]);
    logic [15:0] c;
    c = CRC_INIT;
    foreach (b[i]) begin
      c ^= {8'h00, b[i]};
      repeat (8) c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction
  task automatic seal(ref logic [7:0] q[$]);
    logic [15:0] c;
    c = crc(q);
    q.push_back(c[15:8]);
    q.push_back(c[7:0]);
  endtask
  task automatic cmp_byte(input logic [7:0] g, input logic [7:0] x);
    n_compared++;
    if (g !== x) begin
      n_mismatch++;
      $display("mismatch at %0t: byte %h expected %h", $time, g, x);
    end
  endtask
  task automatic cmp_reg(input logic [15:0] g, input logic [15:0] x);
    n_compared++;
    if (g !== x) begin
      n_mismatch++;
      $display("mismatch at %0t: register %h expected %h", $time, g, x);
    end
  endtask
  task automatic q6(input logic [7:0] fn, input logic [7:0] a, input logic [15:0] w);
    f = {me, fn, 8'h00, a, w[15:8], w[7:0]};
    seal(f);
  endtask
  task automatic ex(input logic [7:0] c);
    e = {f[0], f[1] | EXC_FLAG, c};
    seal(e);
  endtask
  task automatic echo();
    e = f[0:5];
    seal(e);
  endtask
  task automatic tally_and_finish();
    $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // send f, wait bounded for the reply, then let a late or extra byte show
  task automatic xfer();
    int k;
    k = 0;
    u_mst.reply_q.delete();
    u_mst.n_sent = 0;
    u_mst.send_q = f;
    while ((u_mst.send_q.size() > 0 || u_mst.reply_q.size() < e.size()) && k < 10000) begin
      @(negedge ref_clk);
      k++;
    end
    if (k == 10000) begin
      n_mismatch++;
      $display("mismatch at %0t: no reply", $time);
      tally_and_finish();
    end
    repeat (600) @(negedge ref_clk);
    cmp_byte(8'(u_mst.reply_q.size()), 8'(e.size()));
    foreach (e[i]) cmp_byte(u_mst.reply_q[i], e[i]);
    $display("query function %h done", f[1]);
  endtask
  // bit_tick spacing for one rate code; codes above nine fall back
  task automatic chk_rate(input logic [3:0] code);
    int k;
    int i;
    i = (code < 4'hA) ? int'(code) : int'(BAUD_SEL_DEFAULT);
    baud_sel = code;
    repeat (4) @(negedge ref_clk);
    for (k = 0; !bit_tick && k < 4000; k++) @(negedge ref_clk);
    @(negedge ref_clk);
    for (k = 1; !bit_tick && k < 4000; k++) @(negedge ref_clk);
    cmp_reg(16'(k), 16'(SIM_HZ / BAUD_RATE[i]));
    $display("rate code %0d done", code);
    if (k == 4000) tally_and_finish();
  endtask
  task automatic rd_all();
    q6(FN_READ, 8'h00, 16'h000E);
    e = {me, FN_READ, 8'h1C};
    for (int i = 0; i < 14; i++) e = {e, exp_reg[i][15:8], exp_reg[i][7:0]};
    seal(e);
    xfer();
  endtask
  // ***
  // main sequence
  // ***
  initial begin
    v = xs();
    station_addr = v[7:0];
    parity_sel = v[9] ? 2'h2 : {1'b0, v[8]};
    me = v[7:0];
    exp_reg = '0;
    exp_reg[7] = 16'h00FA;
    exp_reg[8] = 16'h0002;
    exp_reg[11] = 16'h0064;
    exp_reg[12] = 16'h00FA;
    exp_reg[13] = 16'h0064;
    repeat (4) @(negedge ref_clk);
    rst = 1'b0;
    repeat (4) @(negedge ref_clk);
    cmp_byte({6'h00, parity_mode}, {6'h00, parity_sel});
    foreach (exp_reg[i]) cmp_reg(param_out[i], exp_reg[i]);
    chk_rate(4'h0);
    chk_rate(4'hC);
    v = xs();
    chk_rate(v[3:0]);
    chk_rate(4'h9);
    rd_all();
    foreach (ri[i]) begin
      q6(FN_PRESET, ri[i], lim[i]);
      echo();
      xfer();
      exp_reg[ri[i][3:0]] = lim[i];
      q6(FN_PRESET, ri[i], lim[i] + 16'h0001);
      ex(8'h03);
      xfer();
    end
    q6(FN_PRESET, 8'h0D, 16'h0000);
    ex(8'h03);
    xfer();
    repeat (3) begin
      v = xs();
      q6(FN_PRESET, {6'h00, v[17:16]}, v[15:0]);
      echo();
      xfer();
      exp_reg[v[17:16]] = v[15:0];
    end
    v = xs();
    f = {me, FN_PRESET_MULTI, 8'h00, 8'h04, 8'h00, 8'h02, 8'h04,
      v[31:24], v[23:16], v[15:8], v[7:0]};
    seal(f);
    echo();
    xfer();
    exp_reg[4] = v[31:16];
    exp_reg[5] = v[15:0];
    // second word bad: nothing of the block may land
    f = {me, FN_PRESET_MULTI, 8'h00, 8'h0C, 8'h00, 8'h02, 8'h04, 8'h00, 8'h01, 8'h00, 8'h00};
    seal(f);
    ex(8'h03);
    xfer();
    // block runs past the last register
    f = {me, FN_PRESET_MULTI, 8'h00, 8'h0D, 8'h00, 8'h02, 8'h04, 8'h00, 8'h01, 8'h00, 8'h01};
    seal(f);
    ex(8'h02);
    xfer();
    foreach (fc[i]) begin
      q6(fc[i], 8'h00, 16'h0001);
      ex(8'h01);
      xfer();
    end
    foreach (ba[i]) begin
      q6(FN_READ, ba[i], 16'h0001);
      ex(8'h02);
      xfer();
    end
    q6(FN_READ, 8'h00, 16'h0050);
    ex(8'h03);
    xfer();
    e = {};
    q6(FN_READ, 8'h00, 16'h0001);
    f[7] = ~f[7];
    xfer();
    q6(FN_PRESET, 8'h00, 16'h0001);
    u_mst.err_at = 3;
    xfer();
    u_mst.err_at = -1;
    me = ~station_addr;
    q6(FN_PRESET, 8'h00, 16'h0001);
    xfer();
    me = station_addr;
    f = {me, FN_PRESET_MULTI, 8'h00, 8'h00, 8'h00, 8'h19, 8'h32};
    repeat (50) f.push_back(8'h00);
    seal(f);
    xfer();
    rd_all();
    foreach (exp_reg[i]) cmp_reg(param_out[i], exp_reg[i]);
    tally_and_finish();
  end
endmodule // modbus_rtu_parameter_slave_tb
`default_nettype wire

/* rtl/mbs_crc_step.sv */
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// one byte of crc16, reflected polynomial
// ****************************************
module mbs_crc_step
  import mbs_pkg::*;
(
  input wire logic [15:0] crc_in,
  input wire logic [7:0] data_in,
  output logic [15:0] crc_out
);

  logic [15:0] c; // working remainder

  // eight shift steps, lsb first
  always_comb begin
    c = crc_in ^ {8'h00, data_in};
    for (int i = 0; i < 8; i++) begin
      if (c[0]) begin
        c = (c >> 1) ^ CRC_POLY;
      end else begin
        c = c >> 1;
      end
    end
    crc_out = c;
  end

endmodule // mbs_crc_step

`default_nettype wire

/* rtl/mbs_pkg.sv */
package mbs_pkg;

  // ****************************************
  // frame and buffer geometry
  // ****************************************
  localparam logic [7:0] NUM_REGS = 8'h0E; // implemented parameter registers
  localparam logic [5:0] BUF_BYTES = 6'h32; // receive buffer capacity, 50 bytes
  localparam logic [5:0] GAP_BITS = 6'h27; // 39 bit times, 3.5 chars of 11 bits
  localparam logic [5:0] LEN_MIN = 6'h04; // address, function, two crc bytes
  localparam logic [5:0] LEN_FIXED = 6'h08; // read and single preset query
  localparam logic [8:0] LEN_MULTI_HDR = 9'h009; // multi preset overhead bytes
  localparam logic [7:0] LEN_EXC = 8'h05; // exception reply
  localparam logic [7:0] LEN_ECHO = 8'h08; // preset echo reply
  localparam logic [7:0] LEN_READ_OVH = 8'h05; // read reply minus data

  // byte positions inside a query
  localparam int POS_ADDR = 0;
  localparam int POS_FN = 1;
  localparam int POS_AHI = 2;
  localparam int POS_ALO = 3;
  localparam int POS_WHI = 4;
  localparam int POS_WLO = 5;
  localparam int POS_BCNT = 6;
  localparam int POS_DATA = 7;
  localparam logic [7:0] POS_RDATA = 8'h03; // first data byte of read reply

  // ****************************************
  // function and exception codes
  // ****************************************
  localparam logic [7:0] FN_READ = 8'h03;
  localparam logic [7:0] FN_PRESET = 8'h06;
  localparam logic [7:0] FN_PRESET_MULTI = 8'h10;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [7:0] MAX_WORDS = 8'h4F; // 79 words per query
  localparam logic [1:0] EXC_NONE = 2'h0;
  localparam logic [1:0] EXC_FUNC = 2'h1;
  localparam logic [1:0] EXC_ADDR = 2'h2;
  localparam logic [1:0] EXC_VALUE = 2'h3;

  // ****************************************
  // crc16
  // ****************************************
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;

  // ****************************************
  // register offsets, limits, reset values
  // ****************************************
  localparam logic [3:0] REG_PRIMARY_SETPOINT = 4'h0;
  localparam logic [3:0] REG_DWELL_TIME = 4'h1;
  localparam logic [3:0] REG_ALARM_ONE_SETPOINT = 4'h2;
  localparam logic [3:0] REG_ALARM_ONE_DEVIATION = 4'h3;
  localparam logic [3:0] REG_ALARM_TWO_SETPOINT = 4'h4;
  localparam logic [3:0] REG_ALARM_TWO_DEVIATION = 4'h5;
  localparam logic [3:0] REG_RAMP_RATE = 4'h6;
  localparam logic [3:0] REG_P_CONTROL_OFFSET = 4'h7;
  localparam logic [3:0] REG_SPECIAL_FUNCTION_CONSTANT = 4'h8;
  localparam logic [3:0] REG_PROCESS_VALUE_SHIFT = 4'h9;
  localparam logic [3:0] REG_PROPORTIONAL_BAND_A = 4'hA;
  localparam logic [3:0] REG_INTEGRAL_TIME_A = 4'hB;
  localparam logic [3:0] REG_DERIVATIVE_TIME_A = 4'hC;
  localparam logic [3:0] REG_COOLING_BAND = 4'hD;

  localparam logic [15:0] OFFSET_MAX = 16'h03E8; // 100.0 percent, tenths
  localparam logic [15:0] OFFSET_DEF = 16'h00FA; // 25.0 percent
  localparam logic [15:0] REF_CONST_MAX = 16'h003C; // 60
  localparam logic [15:0] REF_CONST_DEF = 16'h0002;
  localparam logic [15:0] TI_MAX = 16'h03E8; // 1000 s
  localparam logic [15:0] TI_DEF = 16'h0064; // 100 s
  localparam logic [15:0] TD_MAX = 16'h0E10; // 360.0 s, tenths
  localparam logic [15:0] TD_DEF = 16'h00FA; // 25.0 s
  localparam logic [15:0] COOL_BAND_MIN = 16'h0001;
  localparam logic [15:0] COOL_BAND_MAX = 16'h00FF;
  localparam logic [15:0] COOL_BAND_DEF = 16'h0064; // 100
  localparam logic [15:0] REG_DEF = 16'h0000; // registers without a default

  // ****************************************
  // line configuration
  // ****************************************
  localparam int NUM_BAUDS = 10;
  localparam int BAUD_RATE [NUM_BAUDS] = '{300, 600, 1200, 2400, 4800, 9600,
                                          14400, 19200, 28800, 38400};
  localparam logic [3:0] BAUD_SEL_DEFAULT = 4'h5; // 9600 on an unlisted code
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_EVEN = 2'h1;
  localparam logic [1:0] PAR_ODD = 2'h2;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [4:0] {
    ST_RECV = 5'h01,
    ST_CHECK = 5'h02,
    ST_VERIFY = 5'h04,
    ST_COMMIT = 5'h08,
    ST_REPLY = 5'h10
  } mbs_state_t;

  typedef struct packed {
    logic valid; // one received character
    logic error; // parity or framing fault on it
    logic [7:0] data;
  } mbs_rx_t;

  typedef struct packed {
    logic valid; // reply byte offered
    logic [7:0] data;
  } mbs_tx_t;

  // reset image of the parameter registers
  function automatic logic [13:0][15:0] mbs_reg_reset();
    logic [13:0][15:0] r;
    r = {14{REG_DEF}};
    r[REG_P_CONTROL_OFFSET] = OFFSET_DEF;
    r[REG_SPECIAL_FUNCTION_CONSTANT] = REF_CONST_DEF;
    r[REG_INTEGRAL_TIME_A] = TI_DEF;
    r[REG_DERIVATIVE_TIME_A] = TD_DEF;
    r[REG_COOLING_BAND] = COOL_BAND_DEF;
    return r;
  endfunction

  // per-register accepted value window
  function automatic logic mbs_in_range(input logic [3:0] idx, input logic [15:0] v);
    case (idx)
      REG_P_CONTROL_OFFSET: return v <= OFFSET_MAX;
      REG_SPECIAL_FUNCTION_CONSTANT: return v <= REF_CONST_MAX;
      REG_INTEGRAL_TIME_A: return v <= TI_MAX;
      REG_DERIVATIVE_TIME_A: return v <= TD_MAX;
      REG_COOLING_BAND: return (v >= COOL_BAND_MIN) && (v <= COOL_BAND_MAX);
      default: return 1'b1;
    endcase
  endfunction

endpackage

/* rtl/mbs_slave.sv */
`timescale 1ns/1ps
`default_nettype none

// Contract
// - binary bytes, one stop, selectable parity
// - bit rate picked from ten rates
// - accept only functions 3, 6, 16
// - read query and reply byte layout
// - single preset query byte layout
// - multiple preset query byte layout
// - bad character or crc: silent discard
// - illegal value: five-byte exception reply
// - unsupported function gives exception 1
// - address outside registers gives exception 2
// - value out of range gives exception 3
// - cooling band 1..255, default 100
// - offset 0..100.0 percent, default 25.0
// - reference constant 0..60, default 2
// - integral time 0..1000, default 100
// - derivative time 0..360.0, default 25.0
// - frame bounded by 50-byte buffer
module mbs_slave
  import mbs_pkg::*;
#(
  parameter int CLK_HZ = 125_000_000 // clock rate, scales every bit period
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire mbs_rx_t rx_in,
  input wire logic tx_ready,
  output mbs_tx_t tx_out,
  input wire logic [7:0] station_addr,
  input wire logic [3:0] baud_sel,
  input wire logic [1:0] parity_sel,
  output logic bit_tick,
  output logic [1:0] parity_mode,
  output logic [13:0][15:0] param_out
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    mbs_state_t st; // sequencer
    logic [7:0] sta_meta; // station pins, first stage
    logic [7:0] sta_sync;
    logic [3:0] baud_meta; // rate pins, first stage
    logic [3:0] baud_sync;
    logic [1:0] par_meta; // parity pins, first stage
    logic [1:0] par_sync;
    logic [18:0] div; // bit period divider
    logic tick; // one pulse per bit time
    logic [5:0] gap; // silent bit times after last byte
    logic [5:0] cnt; // bytes held
    logic bad; // frame already spoiled
    logic [15:0] crc; // crc over all bytes
    logic [15:0] crc_p1; // crc without the last byte
    logic [15:0] crc_p2; // crc without the last two
    logic [49:0][7:0] frame; // receive buffer
    logic [13:0][15:0] regs; // parameter registers
    logic [6:0] idx; // word walk index
    logic [1:0] exc; // exception code of reply
    logic [7:0] txi; // reply byte index
    logic [7:0] txlen; // reply length
    logic [15:0] txcrc; // crc over sent bytes
    logic tx_valid;
    logic [7:0] tx_data;
  } mbs_core_t;

  mbs_core_t q; // registered state
  mbs_core_t next_q; // next state

  // ****************************************
  // decode helpers
  // ****************************************
  logic [7:0] fn; // function byte
  logic [7:0] alo; // start address low
  logic [7:0] wlo; // word count low
  logic [7:0] bcnt; // byte count of multi preset
  logic [7:0] n_words; // words to check and write
  logic [3:0] word_reg; // target of current word
  logic [15:0] word_val; // value of current word
  logic word_ok; // value inside its window
  logic crc_ok; // trailing crc matches
  logic chk_drop; // discard frame, say nothing
  logic [1:0] chk_exc; // exception found in check
  logic [15:0] crc_rx_base; // crc seed for the next byte
  logic [15:0] crc_rx_next;
  logic [15:0] crc_tx_next;
  logic [18:0] baud_div; // cycles per bit
  logic [9:0][18:0] div_table; // cycles per bit for each rate

  assign fn = q.frame[POS_FN];
  assign alo = q.frame[POS_ALO];
  assign wlo = q.frame[POS_WLO];
  assign bcnt = q.frame[POS_BCNT];
  assign n_words = (fn == FN_PRESET) ? 8'h01 : wlo;
  assign word_reg = 4'(alo + {1'b0, q.idx});
  // single preset carries its value where the others carry the count
  assign word_val = (fn == FN_PRESET) ? {q.frame[POS_WHI], q.frame[POS_WLO]} :
    {q.frame[POS_DATA + 2 * q.idx], q.frame[POS_DATA + 1 + 2 * q.idx]};
  assign word_ok = mbs_in_range(word_reg, word_val);
  // sender puts the crc high byte first
  assign crc_ok = q.crc_p2 == {q.frame[q.cnt - 6'h02], q.frame[q.cnt - 6'h01]};
  assign crc_rx_base = (q.cnt == 6'h00) ? CRC_INIT : q.crc;

  // ****************************************
  // bit rate table
  // ****************************************
  // constant per entry, so no run-time divider is built
  for (genvar g = 0; g < NUM_BAUDS; g++) begin : g_rate
    assign div_table[g] = 19'(CLK_HZ / BAUD_RATE[g]);
  end

  // unlisted codes fall back to the default rate
  always_comb begin
    if (q.baud_sync < 4'(NUM_BAUDS)) begin
      baud_div = div_table[q.baud_sync];
    end else begin
      baud_div = div_table[BAUD_SEL_DEFAULT];
    end
  end

  // ****************************************
  // crc engines
  // ****************************************
  mbs_crc_step u_crc_rx (
    .crc_in(crc_rx_base),
    .data_in(rx_in.data),
    .crc_out(crc_rx_next)
  );

  mbs_crc_step u_crc_tx (
    .crc_in(q.txcrc),
    .data_in(q.tx_data),
    .crc_out(crc_tx_next)
  );

  // ****************************************
  // query check
  // ****************************************
  // discard beats exception; function beats start address beats count, count beats block end
  always_comb begin
    chk_drop = 1'b0;
    chk_exc = EXC_NONE;
    if (q.bad || q.cnt < LEN_MIN || !crc_ok) begin
      chk_drop = 1'b1;
    end else if (q.frame[POS_ADDR] != q.sta_sync) begin
      chk_drop = 1'b1;
    end else if (fn == FN_READ || fn == FN_PRESET) begin
      chk_drop = q.cnt != LEN_FIXED;
    end else if (fn == FN_PRESET_MULTI) begin
      chk_drop = {3'h0, q.cnt} != LEN_MULTI_HDR + {1'b0, bcnt};
    end else begin
      chk_exc = EXC_FUNC;
    end
    if (!chk_drop && chk_exc == EXC_NONE) begin
      if (q.frame[POS_AHI] != 8'h00 || alo >= NUM_REGS) begin
        chk_exc = EXC_ADDR;
      end else if (fn != FN_PRESET &&
                   (q.frame[POS_WHI] != 8'h00 || wlo == 8'h00 || wlo > MAX_WORDS)) begin
        chk_exc = EXC_VALUE;
      end else if (fn == FN_PRESET_MULTI && bcnt != {wlo[6:0], 1'b0}) begin
        chk_exc = EXC_VALUE;
      end else if (fn != FN_PRESET && {1'b0, alo} + {1'b0, wlo} > {1'b0, NUM_REGS}) begin
        chk_exc = EXC_ADDR;
      end
    end
  end

  // ****************************************
  // reply builder
  // ****************************************
  // byte i of the reply; c is the crc over bytes before i
  function automatic logic [7:0] reply_byte(input logic [7:0] i, input logic [15:0] c);
    logic [3:0] r;
    r = 4'(alo + ((i - POS_RDATA) >> 1));
    if (i == q.txlen - 8'h02) begin
      return c[15:8];
    end else if (i == q.txlen - 8'h01) begin
      // low half from the crc held before its high half went out
      return q.txcrc[7:0];
    end else if (i == 8'h01) begin
      return (q.exc != EXC_NONE) ? (fn | EXC_FLAG) : fn;
    end else if (q.exc != EXC_NONE) begin
      return {6'h00, q.exc};
    end else if (fn == FN_READ && i == 8'h02) begin
      return {wlo[6:0], 1'b0};
    end else if (fn == FN_READ) begin
      return i[0] ? q.regs[r][15:8] : q.regs[r][7:0];
    end
    return q.frame[i[5:0]];
  endfunction

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    next_q = q;
    // configuration pins cross in through two stages
    next_q.sta_meta = station_addr;
    next_q.sta_sync = q.sta_meta;
    next_q.baud_meta = baud_sel;
    next_q.baud_sync = q.baud_meta;
    next_q.par_meta = parity_sel;
    next_q.par_sync = q.par_meta;
    // bit time enable for the character layer and the gap timer
    next_q.tick = 1'b0;
    if (q.div >= baud_div - 19'h00001) begin
      next_q.div = 19'h00000;
      next_q.tick = 1'b1;
    end else begin
      next_q.div = q.div + 19'h00001;
    end
    case (q.st)
      ST_RECV: begin
        // characters arriving outside this state are not looked at
        if (rx_in.valid) begin
          next_q.gap = 6'h00;
          next_q.bad = q.bad | rx_in.error | (q.cnt == BUF_BYTES);
          if (q.cnt < BUF_BYTES) begin
            next_q.frame[q.cnt] = rx_in.data;
            next_q.cnt = q.cnt + 6'h01;
          end
          next_q.crc_p2 = q.crc_p1;
          next_q.crc_p1 = crc_rx_base;
          next_q.crc = crc_rx_next;
        end else if (q.cnt != 6'h00 && q.tick) begin
          // a silence of 3.5 characters closes the frame
          if (q.gap == GAP_BITS - 6'h01) begin
            next_q.st = ST_CHECK;
          end else begin
            next_q.gap = q.gap + 6'h01;
          end
        end
      end
      ST_CHECK: begin
        next_q.exc = chk_exc;
        next_q.idx = 7'h00;
        if (chk_drop) begin
          next_q.st = ST_RECV;
          next_q.cnt = 6'h00;
          next_q.bad = 1'b0;
          next_q.gap = 6'h00;
        end else if (chk_exc != EXC_NONE || fn == FN_READ) begin
          next_q.st = ST_REPLY;
        end else begin
          next_q.st = ST_VERIFY;
        end
      end
      ST_VERIFY: begin
        // every word is checked before any is written
        if (!word_ok) begin
          next_q.exc = EXC_VALUE;
          next_q.st = ST_REPLY;
        end else if ({1'b0, q.idx} == n_words - 8'h01) begin
          next_q.idx = 7'h00;
          next_q.st = ST_COMMIT;
        end else begin
          next_q.idx = q.idx + 7'h01;
        end
      end
      ST_COMMIT: begin
        next_q.regs[word_reg] = word_val;
        if ({1'b0, q.idx} == n_words - 8'h01) begin
          next_q.st = ST_REPLY;
        end else begin
          next_q.idx = q.idx + 7'h01;
        end
      end
      ST_REPLY: begin
        if (q.tx_valid && tx_ready) begin
          next_q.txcrc = crc_tx_next;
          next_q.txi = q.txi + 8'h01;
          if (q.txi + 8'h01 == q.txlen) begin
            next_q.tx_valid = 1'b0;
            next_q.st = ST_RECV;
            next_q.cnt = 6'h00;
            next_q.bad = 1'b0;
            next_q.gap = 6'h00;
            next_q.exc = EXC_NONE;
          end else begin
            next_q.tx_data = reply_byte(q.txi + 8'h01, crc_tx_next);
          end
        end
      end
      default: begin
        next_q.st = ST_RECV;
      end
    endcase
    // reply set-up shared by every way into the reply state
    if (q.st != ST_REPLY && next_q.st == ST_REPLY) begin
      next_q.txi = 8'h00;
      next_q.txcrc = CRC_INIT;
      next_q.tx_valid = 1'b1;
      next_q.tx_data = q.frame[POS_ADDR];
      if (next_q.exc != EXC_NONE) begin
        next_q.txlen = LEN_EXC;
      end else if (fn == FN_READ) begin
        next_q.txlen = LEN_READ_OVH + {wlo[6:0], 1'b0};
      end else begin
        next_q.txlen = LEN_ECHO;
      end
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      q <= '0;
      q.st <= ST_RECV;
      q.regs <= mbs_reg_reset();
      q.crc <= CRC_INIT;
      q.txcrc <= CRC_INIT;
    end else begin
      q <= next_q;
    end
  end

  assign tx_out = {q.tx_valid, q.tx_data};
  assign bit_tick = q.tick;
  assign parity_mode = q.par_sync;
  assign param_out = q.regs;

  // ****************************************
  // checks
  // ****************************************
  a_crc_discard: assert property (@(posedge ref_clk) disable iff (rst)
    (q.st == ST_CHECK && (q.bad || !crc_ok)) |=> (q.st == ST_RECV && !q.tx_valid))
    else $error("spoiled frame was not discarded");

  a_station_match: assert property (@(posedge ref_clk) disable iff (rst)
    (q.st == ST_CHECK && q.frame[POS_ADDR] != q.sta_sync) |=> q.st == ST_RECV)
    else $error("foreign station query was answered");

  a_bad_function: assert property (@(posedge ref_clk) disable iff (rst)
    (q.st == ST_CHECK && !chk_drop && fn != FN_READ && fn != FN_PRESET &&
     fn != FN_PRESET_MULTI) |=> (q.st == ST_REPLY && q.exc == EXC_FUNC))
    else $error("unsupported function not answered with code 1");

  a_commit_fn: assert property (@(posedge ref_clk) disable iff (rst)
    q.st == ST_COMMIT |-> (fn == FN_PRESET || fn == FN_PRESET_MULTI))
    else $error("write by an unsupported function");

  a_exc_shape: assert property (@(posedge ref_clk) disable iff (rst)
    (q.st == ST_REPLY && q.exc != EXC_NONE && q.tx_valid && q.txi == 8'h01) |->
    (q.txlen == LEN_EXC && q.tx_data == (fn | EXC_FLAG)))
    else $error("exception reply malformed");

  a_addr_range: assert property (@(posedge ref_clk) disable iff (rst)
    (q.st == ST_CHECK && !chk_drop && chk_exc == EXC_NONE) |->
    ({1'b0, alo} + {1'b0, n_words} <= {1'b0, NUM_REGS}))
    else $error("out of range address accepted");

  a_value_guard: assert property (@(posedge ref_clk) disable iff (rst)
    (q.st == ST_VERIFY && !word_ok) |=> (q.st == ST_REPLY && q.exc == EXC_VALUE &&
    $stable(q.regs)))
    else $error("bad value not refused with code 3");

  a_cool_band: assert property (@(posedge ref_clk) disable iff (rst)
    q.regs[REG_COOLING_BAND] >= COOL_BAND_MIN && q.regs[REG_COOLING_BAND] <= COOL_BAND_MAX)
    else $error("cooling band left its window");

  a_deriv_band: assert property (@(posedge ref_clk) disable iff (rst)
    q.regs[REG_DERIVATIVE_TIME_A] <= TD_MAX && q.regs[REG_INTEGRAL_TIME_A] <= TI_MAX)
    else $error("time constant left its window");

  a_buf_bound: assert property (@(posedge ref_clk) disable iff (rst)
    (q.st == ST_RECV && rx_in.valid && q.cnt == BUF_BYTES) |=> (q.bad && q.cnt == BUF_BYTES))
    else $error("overlong frame not spoiled");

  a_echo_len: assert property (@(posedge ref_clk) disable iff (rst)
    (q.st == ST_COMMIT && next_q.st == ST_REPLY) |=> (q.txlen == LEN_ECHO && q.tx_valid))
    else $error("preset echo has wrong length");

endmodule // mbs_slave

`default_nettype wire
